// file: tb/wsl_stat_src.sv
/*
 Far side status transmitter: a frame of calendar words, zero pad, then training.
 Assumes start is a level raised by the bench; clock stands still between frames.
*/
module wsl_stat_src (
	input  wire logic        start,
	input  wire logic        bad,
	input  wire logic [15:0] mask,
	output logic             stat_clk,
	output logic [15:0]      stat_in,
	output logic             busy
);
	timeunit 1ns;
	timeprecision 100ps;
	// Lines beyond the width toggle so masking is really exercised
	task automatic send(input logic [15:0] w);
		stat_in = (w & mask) | (~stat_in & ~mask);
		#62.5;
		stat_clk = 1'b1;
		#62.5;
		stat_clk = 1'b0;
	endtask
	initial begin
		stat_clk = 1'b0;
		stat_in = 16'h0;
		busy = 1'b0;
		forever begin
			@(posedge start);
			busy = 1'b1;
			if (bad)
				send(16'hFFFF);
			send(16'h6666);
			send(16'h0009);
			send(16'h0000);
			repeat (10) send(16'h0000);
			repeat (10) send(16'hFFFF);
			busy = 1'b0;
		end
	end
endmodule // wsl_stat_src

// file: tb/wsl_wide_tx_chk.sv
/*
 Port assertions for the wide striping transmitter.
 Assumes mode_cfg and wide_status change only while the link is down.
*/
module wsl_wide_tx_chk #(
	parameter logic [15:0] IDLE_CTRL_WORD  = 16'h000F,
	parameter logic [15:0] TRAIN_CTRL_WORD = 16'h0FFF,
	parameter logic [15:0] TRAIN_DATA_WORD = 16'hF000
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [1:0]  mode_cfg,
	input wire logic        wide_status,
	input wire logic [63:0] in_word,
	input wire logic [3:0]  in_ctl,
	input wire logic [2:0]  in_count,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic [63:0] wide_word_bus,
	input wire logic [3:0]  control_word_flag,
	input wire logic [3:0]  lane_source_clock,
	input wire logic        training,
	input wire logic [15:0] stat_word,
	input wire logic        stat_strobe,
	input wire logic        stat_trained,
	input wire logic        stat_sync_lost
);
	int          nl;
	logic [3:0]  lm;
	logic [63:0] wm;
	logic [15:0] sm;
	logic [6:0]  tcnt;
	logic [6:0]  next_tcnt;
	assign nl = mode_cfg == 2'h2 ? 4 : mode_cfg == 2'h1 ? 2 : 1;
	assign lm = 4'((5'h1 << nl) - 5'h1);
	assign wm = {{16{lm[3]}}, {16{lm[2]}}, {16{lm[1]}}, {16{lm[0]}}};
	assign sm = 16'((17'h1 << (nl * (wide_status ? 4 : 2))) - 17'h1);
	// Cycles spent in training; the phase split needs it
	always_comb next_tcnt = training ? tcnt + 7'h1 : 7'h0;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			tcnt <= 7'h0;
		else
			tcnt <= next_tcnt;
	end
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_tick;
		$fell(lane_source_clock[0]);
	endsequence
	sequence s_high_half;
		lane_source_clock[0] [*2] ##1 !lane_source_clock[0];
	endsequence
	sequence s_take(logic [1:0] m, logic [2:0] n);
		in_ready && in_valid && mode_cfg == m && in_count == n;
	endsequence
	a_clk_same: assert property (lane_source_clock inside {4'h0, 4'hF})
		else $error("lane clocks differ");
	a_clk_half: assert property ($rose(lane_source_clock[0]) |-> s_high_half)
		else $error("lane clock half period wrong");
	a_bus_tick: assert property (!$stable({wide_word_bus, control_word_flag}) |-> s_tick)
		else $error("bus moved off the falling lane clock");
	a_ready_tick: assert property (in_ready |-> !training ##1 s_tick)
		else $error("ready outside a run tick");
	a_quad_order: assert property (s_take(2'h2, 3'h4) |=> wide_word_bus == $past(in_word)
		&& control_word_flag == $past(in_ctl))
		else $error("quad striping wrong");
	a_dual_order: assert property (s_take(2'h1, 3'h2) |=> wide_word_bus == ($past(in_word) & 64'hFFFFFFFF)
		&& control_word_flag == ($past(in_ctl) & 4'h3))
		else $error("dual striping wrong");
	a_idle_pad: assert property (in_ready && !in_valid |=> control_word_flag == lm
		&& wide_word_bus == ({4{IDLE_CTRL_WORD}} & wm))
		else $error("empty transfer not idle words");
	// Training flag leads the bus by one transfer: the first four cycles still show the last transfer loaded in the run or idle state
	a_train_ctl: assert property (training && tcnt >= 7'h04 && tcnt < 7'h2C |-> control_word_flag == lm
		&& wide_word_bus == ({4{TRAIN_CTRL_WORD}} & wm))
		else $error("control training word wrong");
	a_train_dat: assert property (training && tcnt >= 7'h2C |-> control_word_flag == 4'h0
		&& wide_word_bus == ({4{TRAIN_DATA_WORD}} & wm))
		else $error("data training word wrong");
	a_train_len: assert property ($fell(training) |-> tcnt == 7'h50)
		else $error("training length wrong");
	a_stat_width: assert property (stat_strobe |-> (stat_word & ~sm) == 16'h0)
		else $error("status bits beyond width");
	a_stat_trained: assert property (stat_trained |-> stat_strobe && stat_word == sm)
		else $error("status trained without ones word");
	a_pad_no_loss: assert property ($rose(stat_sync_lost) |-> stat_word != 16'h0)
		else $error("zero word raised sync loss");
endmodule // wsl_wide_tx_chk

// file: tb/wsl_wide_tx_tb.sv
/*
 Self-checking bench for the wide striping transmitter with a status partner.
 Assumes design parameters at their defaults.
*/
module wsl_wide_tx_tb import wsl_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk, rst, link_en, wide_status, train_req, in_valid, in_ready, training;
	logic        st_go, st_bad, stat_clk, st_busy, stat_strobe, stat_trained, stat_sync_lost;
	logic [1:0]  mode_cfg;
	logic [2:0]  in_count;
	logic [3:0]  in_ctl, control_word_flag, lane_source_clock;
	logic [15:0] stat_in, stat_word, st_mask;
	logic [63:0] in_word, wide_word_bus;
	int          seed, error_cnt, n_tests, cyc, nl;
	wsl_wide_tx DUT (.sys_clk, .rst, .link_en, .mode_cfg, .wide_status, .train_req, .in_word, .in_ctl, .in_count,
		.in_valid, .in_ready, .wide_word_bus, .control_word_flag, .lane_source_clock, .training, .stat_clk,
		.stat_in, .stat_word, .stat_strobe, .stat_trained, .stat_sync_lost);
	wsl_stat_src SRC (.start(st_go), .bad(st_bad), .mask(st_mask), .stat_clk, .stat_in, .busy(st_busy));
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_bus(input logic [67:0] e);
		n_tests++;
		if ({control_word_flag, wide_word_bus} !== e) begin
			error_cnt++;
			$display("unexpected at %0t: bus %h want %h", $time, {control_word_flag, wide_word_bus}, e);
		end
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] e, input string what);
		n_tests++;
		if (got !== e) begin
			error_cnt++;
			$display("unexpected at %0t: %s %0h want %0h", $time, what, got, e);
		end
	endtask
	// Lane g holds user slot g; the top n lanes carry data, lanes below them carry idle control words
	function automatic logic [67:0] exp_xfer(input logic [63:0] w, input logic [3:0] c, input int n);
		logic [67:0] r;
		r = 68'h0;
		for (int g = 0; g < nl; g++) begin
			r[g*16+:16] = nl - 1 - g < n ? w[g*16+:16] : 16'h000F;
			r[64+g] = nl - 1 - g < n ? c[g] : 1'b1;
		end
		return r;
	endfunction
	task automatic xfer(input logic v, input int n);
		int t;
		logic [67:0] e;
		in_valid = v;
		in_count = 3'(n);
		in_word = {$random(seed), $random(seed)};
		in_ctl = 4'($random(seed));
		e = exp_xfer(in_word, in_ctl, v ? n : 0);
		t = 0;
		do begin
			@(negedge sys_clk);
			t++;
		end while (in_ready !== 1'b1 && t < 60);
		@(posedge sys_clk);
		#1;
		in_valid = 1'b0;
		@(posedge sys_clk);
		#1;
		chk_bus(e);
	endtask
	task automatic train_len();
		int t;
		int c;
		t = 0;
		c = 0;
		while (training !== 1'b1 && t < 60) begin
			@(negedge sys_clk);
			t++;
		end
		while (training === 1'b1 && c < 200) begin
			@(negedge sys_clk);
			c++;
		end
		chk_val(c, 4 * TRAIN_REPS * LANE_HALF_CYCLES, "training cycles");
		@(posedge sys_clk);
		#1;
	endtask
	task automatic stat_run(input logic b);
		int t;
		int hits;
		logic lost;
		st_bad = b;
		st_go = 1'b1;
		t = 0;
		hits = 0;
		lost = 1'b0;
		do begin
			@(negedge sys_clk);
			t++;
			hits += int'(stat_trained === 1'b1);
			lost |= stat_sync_lost === 1'b1;
		end while ((t < 4 || st_busy === 1'b1) && t < 3000);
		#1;
		st_go = 1'b0;
		repeat (20) @(posedge sys_clk);
		#1;
		chk_val(hits, 1, "trained pulses");
		chk_val(lost, b, "sync loss seen");
		chk_val(stat_sync_lost, 0, "sync loss after training");
		chk_val(stat_word, st_mask, "status word");
	endtask
	initial begin
		{sys_clk, link_en, wide_status, train_req, in_valid, st_go, st_bad} = '0;
		{rst, mode_cfg, in_count, in_ctl, in_word, st_mask, cyc, error_cnt, n_tests} = {1'b1, 73'h0, 16'h3, 96'h0};
		seed = 32'hA45A;
		repeat (20) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		for (int m = 0; m < 4; m++) begin
			link_en = 1'b0;
			repeat (30) @(posedge sys_clk);
			#1;
			mode_cfg = 2'(m);
			wide_status = mode_cfg[0];
			nl = m == 2 ? 4 : m == 1 ? 2 : 1;
			st_mask = 16'((17'h1 << (nl * (wide_status ? 4 : 2))) - 17'h1);
			repeat (4) @(posedge sys_clk);
			#1;
			link_en = 1'b1;
			train_len();
			xfer(1'b1, nl);
			xfer(1'b0, 0);
			xfer(1'b1, 0);
			repeat (12) xfer(1'b1, {$random(seed)} % (nl + 1));
			train_req = 1'b1;
			@(posedge sys_clk);
			#1;
			train_req = 1'b0;
			train_len();
			xfer(1'b1, nl);
			stat_run(mode_cfg[0]);
			$display("test mode %0d done, mismatches %0d", m, error_cnt);
		end
		give_verdict();
	end
endmodule // wsl_wide_tx_tb
bind wsl_wide_tx wsl_wide_tx_chk #(.IDLE_CTRL_WORD(IDLE_CTRL_WORD), .TRAIN_CTRL_WORD(TRAIN_CTRL_WORD),
	.TRAIN_DATA_WORD(TRAIN_DATA_WORD)) CHK (.sys_clk, .rst, .mode_cfg, .wide_status, .in_word, .in_ctl, .in_count,
	.in_valid, .in_ready, .wide_word_bus, .control_word_flag, .lane_source_clock, .training, .stat_word,
	.stat_strobe, .stat_trained, .stat_sync_lost);

// file: verilog/wsl_lane.sv
/*
 One 16-bit lane output stage: word, control flag and forwarded lane clock, all registered.
 Assumes the controller gives load only on the falling lane clock edge so data is centred.
*/
module wsl_lane (
	input  wire logic sys_clk,
	input  wire logic rst,
	wsl_lane_if.lane  bus
);
	import wsl_pkg::*;

	logic [LANE_W-1:0] next_word;
	logic              next_ctl;

	always_comb begin
		next_word = bus.word;
		next_ctl  = bus.ctl;
		if (bus.load) begin
			next_word = bus.word_next;
			next_ctl  = bus.ctl_next;
		end
	end

	// Word, flag and clock share one register stage so they stay frequency locked
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus.word <= '0;
			bus.ctl  <= 1'b0;
			bus.clk  <= 1'b0;
		end else begin
			bus.word <= next_word;
			bus.ctl  <= next_ctl;
			bus.clk  <= bus.clk_next;
		end
	end
endmodule // wsl_lane

// file: verilog/wsl_lane_if.sv
/*
 Carrier between the striping controller and one 16-bit lane output stage.
 Assumes both ends run on sys_clk.
*/
interface wsl_lane_if;
	logic [wsl_pkg::LANE_W-1:0] word_next;
	logic                       ctl_next;
	logic                       load;
	logic                       clk_next;
	logic [wsl_pkg::LANE_W-1:0] word;
	logic                       ctl;
	logic                       clk;

	modport drv  (output word_next, output ctl_next, output load, output clk_next,
	              input word, input ctl, input clk);
	modport lane (input word_next, input ctl_next, input load, input clk_next,
	              output word, output ctl, output clk);
endinterface

// file: verilog/wsl_pkg.sv
/*
 Shared constants, types and decode helpers for the wide lane striping transmitter.
 Assumes a single 125 MHz system clock domain on the device side.
*/
package wsl_pkg;
	localparam int LANE_W             = 16;
	localparam int MAX_LANES          = 4;
	localparam int BUS_W              = 64;
	localparam int STAT_MAX_W         = 16;
	localparam int TRAIN_REPS         = 10;
	localparam int SYS_CLK_PERIOD_NS  = 8;
	localparam int MIN_LANE_RATE_MBPS = 622;
	// Lane clock half period in system cycles; each transfer lasts one lane clock period
	localparam int LANE_HALF_CYCLES   = 2;
	localparam int LANE_CLK_PERIOD_NS = 2 * LANE_HALF_CYCLES * SYS_CLK_PERIOD_NS;
	localparam logic [3:0] RST_REP    = 4'h0;
	localparam logic [3:0] RUN_MAX    = 4'hF;

	typedef enum logic [1:0] {
		WSL_MODE_SINGLE = 2'h0,
		WSL_MODE_DUAL   = 2'h1,
		WSL_MODE_QUAD   = 2'h2
	} wsl_mode_t;

	typedef enum logic [3:0] {
		WSL_ST_IDLE      = 4'h1,
		WSL_ST_RUN       = 4'h2,
		WSL_ST_TRAIN_CTL = 4'h4,
		WSL_ST_TRAIN_DAT = 4'h8
	} wsl_state_t;

	function automatic logic [2:0] wsl_lanes(input wsl_mode_t m);
		case (m)
			WSL_MODE_QUAD: wsl_lanes = 3'h4;
			WSL_MODE_DUAL: wsl_lanes = 3'h2;
			default:       wsl_lanes = 3'h1;
		endcase
	endfunction

	// Two status bits per lane, four with the wide status option
	function automatic logic [STAT_MAX_W-1:0] wsl_stat_mask(input logic [2:0] lanes, input logic wide);
		logic [4:0] bits;
		bits = wide ? {lanes, 2'h0} : {1'b0, lanes, 1'b0};
		wsl_stat_mask = STAT_MAX_W'((17'h00001 << bits) - 17'h00001);
	endfunction
endpackage

// file: verilog/wsl_wide_tx.sv
/*
 Wide aggregated mode source: stripes 16-bit words over one, two or four lanes,
 forwards one clock per lane, runs full-width training and watches the return status bus.
 Assumes user side logic on sys_clk; pins and configuration straps arrive asynchronously.
*/
// Notes on behaviour
// - Dual: first byte on 31:24, last 7:0
// - Quad: first byte on 63:56, last 7:0
// - Within each byte MSB first, LSB last
// - Every lane and flag at least 622 Mbps; here each lane moves one 16-bit word per 32 ns lane clock period
// - Dual: flag 1 for 31:16, flag 0 for 15:0
// - Quad: flag 3 for 63:48, flag 0 for 15:0
// - Each lane and flag locked to its clock
// - Training spans full data and status width
// - Ten training control then ten training data words
// - Pad partial last transfer with idle control words
// - Zero padding never flags status sync loss
// - Support 16-bit path; narrow mode optional
// - Dual: high half first word, low half second
// - One state machine drives all lanes together
// - One clock per lane, one status clock
module wsl_wide_tx #(
	parameter logic [15:0] IDLE_CTRL_WORD  = 16'h000F,
	parameter logic [15:0] TRAIN_CTRL_WORD = 16'h0FFF,
	parameter logic [15:0] TRAIN_DATA_WORD = 16'hF000
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         link_en,
	input  wire logic [1:0]                   mode_cfg,
	input  wire logic                         wide_status,
	input  wire logic                         train_req,
	input  wire logic [wsl_pkg::BUS_W-1:0]    in_word,
	input  wire logic [wsl_pkg::MAX_LANES-1:0] in_ctl,
	input  wire logic [2:0]                   in_count,
	input  wire logic                         in_valid,
	output logic                              in_ready,
	output logic [wsl_pkg::BUS_W-1:0]         wide_word_bus,
	output logic [wsl_pkg::MAX_LANES-1:0]     control_word_flag,
	output logic [wsl_pkg::MAX_LANES-1:0]     lane_source_clock,
	output logic                              training,
	input  wire logic                         stat_clk,
	input  wire logic [wsl_pkg::STAT_MAX_W-1:0] stat_in,
	output logic [wsl_pkg::STAT_MAX_W-1:0]    stat_word,
	output logic                              stat_strobe,
	output logic                              stat_trained,
	output logic                              stat_sync_lost
);
	import wsl_pkg::*;

	// A 125 MHz fabric clock cannot reach the lane rate alone; a DDR serialiser
	// behind these pins multiplies the parallel transfer rate.
	localparam int MIN_LANE_PERIOD_PS = 1000000 / MIN_LANE_RATE_MBPS;

	logic [1:0]  en_sync;
	logic [1:0]  mode_s1;
	logic [1:0]  mode_s2;
	logic [1:0]  wst_sync;
	wsl_state_t  state;
	wsl_state_t  next_state;
	wsl_mode_t   mode;
	wsl_mode_t   next_mode;
	logic        wst;
	logic        next_wst;
	logic [3:0]  rep;
	logic [3:0]  next_rep;
	logic [3:0]  hc;
	logic [3:0]  next_hc;
	logic        ph;
	logic        next_ph;
	logic        tick;
	logic        train_pend;
	logic        next_train_pend;
	logic        next_in_ready;
	logic        next_training;
	logic [2:0]  lanes;
	logic [LANE_W-1:0]    lane_word [MAX_LANES];
	logic [MAX_LANES-1:0] lane_ctl;

	assign lanes = wsl_lanes(mode);
	assign tick  = (hc == 4'(LANE_HALF_CYCLES - 1)) && ph;

	always_comb begin
		next_hc = (hc == 4'(LANE_HALF_CYCLES - 1)) ? 4'h0 : 4'(hc + 4'h1);
		next_ph = (hc == 4'(LANE_HALF_CYCLES - 1)) ? ~ph : ph;
		next_state      = state;
		next_rep        = rep;
		next_mode       = mode;
		next_wst        = wst;
		next_train_pend = train_req | train_pend;
		if (state == WSL_ST_IDLE) begin
			next_mode = wsl_mode_t'(mode_s2);
			next_wst  = wst_sync[1];
		end
		if (tick) begin
			case (state)
				WSL_ST_IDLE: begin
					if (en_sync[1]) begin
						next_state      = WSL_ST_TRAIN_CTL;
						next_rep        = RST_REP;
						next_train_pend = train_req;
					end
				end
				WSL_ST_RUN: begin
					if (!en_sync[1]) begin
						next_state = WSL_ST_IDLE;
					end else if (train_pend) begin
						next_state      = WSL_ST_TRAIN_CTL;
						next_rep        = RST_REP;
						next_train_pend = train_req;
					end
				end
				WSL_ST_TRAIN_CTL: begin
					next_rep = 4'(rep + 4'h1);
					if (rep == 4'(TRAIN_REPS - 1)) begin
						next_state = WSL_ST_TRAIN_DAT;
						next_rep   = RST_REP;
					end
				end
				WSL_ST_TRAIN_DAT: begin
					next_rep = 4'(rep + 4'h1);
					if (rep == 4'(TRAIN_REPS - 1)) begin
						next_state = en_sync[1] ? WSL_ST_RUN : WSL_ST_IDLE;
						next_rep   = RST_REP;
					end
				end
				default: next_state = WSL_ST_IDLE;
			endcase
		end
		next_in_ready = (next_hc == 4'(LANE_HALF_CYCLES - 1)) && next_ph &&
		                (next_state == WSL_ST_RUN) && !next_train_pend && en_sync[1];
		next_training = (next_state == WSL_ST_TRAIN_CTL) || (next_state == WSL_ST_TRAIN_DAT);
	end

	// One machine picks the words for every lane in the same transfer
	always_comb begin
		int k;
		int p;
		k = 0;
		p = 0;
		for (int g = 0; g < MAX_LANES; g++) begin
			lane_word[g] = '0;
			lane_ctl[g]  = 1'b0;
			if (g < int'(lanes)) begin
				// User slots sit on the lanes of the same position, so lane g takes slot g
				k = int'(lanes) - 1 - g;
				p = g;
				case (state)
					WSL_ST_RUN: begin
						if (in_valid && in_ready && (k < int'(in_count))) begin
							// First word on the highest active lane, bytes kept in order
							lane_word[g] = in_word[p*LANE_W +: LANE_W];
							lane_ctl[g]  = in_ctl[p];
						end else begin
							lane_word[g] = IDLE_CTRL_WORD;
							lane_ctl[g]  = 1'b1;
						end
					end
					WSL_ST_TRAIN_CTL: begin
						lane_word[g] = TRAIN_CTRL_WORD;
						lane_ctl[g]  = 1'b1;
					end
					WSL_ST_TRAIN_DAT: begin
						lane_word[g] = TRAIN_DATA_WORD;
						lane_ctl[g]  = 1'b0;
					end
					default: begin
						lane_word[g] = '0;
						lane_ctl[g]  = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_sync    <= 2'h0;
			mode_s1    <= 2'h0;
			mode_s2    <= 2'h0;
			wst_sync   <= 2'h0;
			state      <= WSL_ST_IDLE;
			mode       <= WSL_MODE_SINGLE;
			wst        <= 1'b0;
			rep        <= RST_REP;
			hc         <= 4'h0;
			ph         <= 1'b0;
			train_pend <= 1'b0;
			in_ready   <= 1'b0;
			training   <= 1'b0;
		end else begin
			en_sync    <= {en_sync[0], link_en};
			mode_s1    <= mode_cfg;
			mode_s2    <= mode_s1;
			wst_sync   <= {wst_sync[0], wide_status};
			state      <= next_state;
			mode       <= next_mode;
			wst        <= next_wst;
			rep        <= next_rep;
			hc         <= next_hc;
			ph         <= next_ph;
			train_pend <= next_train_pend;
			in_ready   <= next_in_ready;
			training   <= next_training;
		end
	end

	// Each lane is a fixed 16-bit stage with its own forwarded clock
	wsl_lane_if lb [MAX_LANES] ();
	for (genvar g = 0; g < MAX_LANES; g++) begin : g_lane
		assign lb[g].word_next = lane_word[g];
		assign lb[g].ctl_next  = lane_ctl[g];
		assign lb[g].load      = tick;
		assign lb[g].clk_next  = next_ph;
		assign wide_word_bus[g*LANE_W +: LANE_W] = lb[g].word;
		assign control_word_flag[g] = lb[g].ctl;
		assign lane_source_clock[g] = lb[g].clk;
		wsl_lane u_lane (
			.sys_clk (sys_clk),
			.rst     (rst),
			.bus     (lb[g])
		);
	end

	// Status return path: one clock for the whole bus, sampled after two flops
	logic [STAT_MAX_W-1:0] st_s1;
	logic [STAT_MAX_W-1:0] st_s2;
	logic [2:0]            sck;
	logic [STAT_MAX_W-1:0] smask;
	logic                  s_edge;
	logic                  s_zero;
	logic                  s_one;
	logic [3:0]            zero_run;
	logic [3:0]            next_zero_run;
	logic [3:0]            one_run;
	logic [3:0]            next_one_run;
	logic                  zeros_done;
	logic                  next_zeros_done;
	logic [STAT_MAX_W-1:0] next_stat_word;
	logic                  next_stat_trained;
	logic                  next_sync_lost;

	assign smask  = wsl_stat_mask(lanes, wst);
	assign s_edge = sck[1] && !sck[2];
	assign s_zero = (st_s2 & smask) == '0;
	assign s_one  = (st_s2 & smask) == smask;

	always_comb begin
		next_zero_run     = zero_run;
		next_one_run      = one_run;
		next_zeros_done   = zeros_done;
		next_stat_word    = stat_word;
		next_stat_trained = 1'b0;
		next_sync_lost    = stat_sync_lost;
		if (s_edge) begin
			// Lines are kept in place so odd and even entries stay on their pairs
			next_stat_word = st_s2 & smask;
			next_zero_run  = s_zero ? ((zero_run == RUN_MAX) ? RUN_MAX : 4'(zero_run + 4'h1)) : 4'h0;
			next_one_run   = s_one ? ((one_run == RUN_MAX) ? RUN_MAX : 4'(one_run + 4'h1)) : 4'h0;
			if (s_zero && zero_run >= 4'(TRAIN_REPS - 1)) begin
				next_zeros_done = 1'b1;
			end
			if (!s_zero && !s_one) begin
				next_zeros_done = 1'b0;
			end
			if (s_one && zeros_done && one_run == 4'(TRAIN_REPS - 1)) begin
				next_stat_trained = 1'b1;
				next_sync_lost    = 1'b0;
				next_zeros_done   = 1'b0;
			end else if (s_one && !zeros_done) begin
				next_sync_lost = 1'b1;
			end
			// Zero words, padding included, never raise the loss flag
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_s1          <= '0;
			st_s2          <= '0;
			sck            <= 3'h0;
			zero_run       <= 4'h0;
			one_run        <= 4'h0;
			zeros_done     <= 1'b0;
			stat_word      <= '0;
			stat_strobe    <= 1'b0;
			stat_trained   <= 1'b0;
			stat_sync_lost <= 1'b0;
		end else begin
			st_s1          <= stat_in;
			st_s2          <= st_s1;
			sck            <= {sck[1:0], stat_clk};
			zero_run       <= next_zero_run;
			one_run        <= next_one_run;
			zeros_done     <= next_zeros_done;
			stat_word      <= next_stat_word;
			stat_strobe    <= s_edge;
			stat_trained   <= next_stat_trained;
			stat_sync_lost <= next_sync_lost;
		end
	end
endmodule // wsl_wide_tx
